// *** src/tmr_timer0.sv ***
// 8-bit timer with asynchronous clock option, update-busy tracking,
// interrupt enables and flags, and prescaler reset control.
// assumes a classic wishbone master on clk_i and an async clock pin
// (crystal or external clock) far slower than clk_i.
// Function
// - external clock enable stops the crystal; the buffer turns on only with select one
// - select zero: clocked from system clock
// - select one: crystal or external clock pin
// - select change may clear count, compare, control A
// - select can be written to one only with rc clock
// - async writes set busy until transfer done
// - count reads live, others read temporary copy
// - compare interrupt needs enable, global, flag
// - overflow interrupt needs enable, global, flag
// - count equal compare sets compare flag
// - flags clear by vector or writing one
// - overflow at max, phase mode at bottom
// - reserved bits always read zero
// - prescaler reset bit clears right after reset
// - async prescaler reset holds until done
// - sync mode keeps prescaler reset bit set
// - sync mode zero releases held prescaler reset
//
// Added by the designer: the Wishbone slave port.
module tmr_timer0
  import tmr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        async_clk_i,
  input  wire logic        sys_clk_from_rc_i,
  input  wire logic        global_irq_en_i,
  input  wire logic        cmp_vector_ack_i,
  input  wire logic        ovf_vector_ack_i,
  output logic             compare_irq_o,
  output logic             overflow_irq_o,
  output logic             crystal_osc_en_o,
  output logic             ext_clk_buf_en_o,
  output logic [7:0]       count_value_o
);

  tmr_state_s q;
  tmr_state_s d;

  // clock select tap: one means every source event, zero stops, else prescaler wraps
  function automatic logic tap_hit(input logic [2:0] cs, input logic [9:0] p);
    logic hit;
    hit = 1'b0;
    case (cs)
      3'h1:    hit = 1'b1;
      3'h2:    hit = &p[2:0];
      3'h3:    hit = &p[4:0];
      3'h4:    hit = &p[5:0];
      3'h5:    hit = &p[6:0];
      3'h6:    hit = &p[7:0];
      3'h7:    hit = &p[9:0];
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic       req;
  logic       wr;
  logic [7:0] idx;
  logic [7:0] wb;
  logic       aedge;
  logic       src_evt;
  logic       tick;
  logic       cmp_set;
  logic       ovf_set;
  logic       new_as;
  logic [7:0] rd;

  always_comb
  begin
    d       = q;
    req     = cyc_i & stb_i & ~q.ack;
    wr      = req & we_i & sel_i[0];
    idx     = adr_i[9:2];
    wb      = dat_i[7:0];
    cmp_set = 1'b0;
    ovf_set = 1'b0;
    new_as  = q.asy.async_sel;
    rd      = TMR_RST_BYTE;

    // async pin synchroniser, third stage feeds the edge detector
    d.aclk_s1 = async_clk_i;
    d.aclk_s2 = q.aclk_s1;
    d.aclk_s3 = q.aclk_s2;
    aedge     = q.aclk_s2 & ~q.aclk_s3;

    // source of timer events: system clock or synchronised async edge
    src_evt = q.asy.async_sel ? aedge : 1'b1;

    // prescaler, held at zero while reset is requested
    if (q.psc_reset)
    begin
      if (src_evt)
        d.psc = '0;
    end
    else if (src_evt)
      d.psc = q.psc + 10'h001;
    tick = src_evt & ~q.psc_reset & tap_hit(q.ctrl_b[2:0], q.psc);

    // prescaler reset bit: async waits for a real edge, sync clears now
    if (q.psc_reset && !q.sync_mode && (!q.asy.async_sel || aedge))
      d.psc_reset = 1'b0;

    // async transfer of temporary copies on the timer clock edge
    if (q.asy.async_sel && aedge)
    begin
      if (q.asy.busy[3])
        d.count = q.tmp_count;
      if (q.asy.busy[2])
        d.compare = q.tmp_compare;
      if (q.asy.busy[1])
        d.ctrl_a = q.tmp_ctrl_a;
      if (q.asy.busy[0])
        d.ctrl_b = q.tmp_ctrl_b;
      d.asy.busy = 4'h0;
    end

    // counter; a loaded count skips this tick so the new value stands
    if (tick && !(q.asy.async_sel && q.asy.busy[3]))
    begin
      d.block_cmp = 1'b0;
      cmp_set     = (q.count == q.compare) && !q.block_cmp;
      case (q.ctrl_a[1:0])
        TMR_WGM_PHASE:
        begin
          if (q.count_down && q.count == TMR_BOTTOM)
          begin
            d.count_down = 1'b0;
            d.count      = q.count + 8'h01;
            ovf_set      = 1'b1;
          end
          else if (!q.count_down && q.count == TMR_MAX)
          begin
            d.count_down = 1'b1;
            d.count      = q.count - 8'h01;
          end
          else
            d.count = q.count_down ? q.count - 8'h01 : q.count + 8'h01;
        end
        TMR_WGM_CTC:
        begin
          d.count = (q.count == q.compare) ? TMR_BOTTOM : q.count + 8'h01;
          ovf_set = (q.count == TMR_MAX);
        end
        default:
        begin
          d.count = q.count + 8'h01;
          ovf_set = (q.count == TMR_MAX);
        end
      endcase
    end

    // flags: vector or write-one clears, a set in the same cycle wins
    if (cmp_vector_ack_i)
      d.cmp_flag = 1'b0;
    if (ovf_vector_ack_i)
      d.ovf_flag = 1'b0;

    // register writes on the request cycle
    if (wr)
    begin
      case (idx)
        TMR_IDX_IRQ_FLAGS:
        begin
          if (wb[TMR_BIT_CMP])
            d.cmp_flag = 1'b0;
          if (wb[TMR_BIT_OVF])
            d.ovf_flag = 1'b0;
        end
        TMR_IDX_IRQ_MASK:
        begin
          d.cmp_irq_en = wb[TMR_BIT_CMP];
          d.ovf_irq_en = wb[TMR_BIT_OVF];
        end
        TMR_IDX_ASYNC_ST:
        begin
          d.asy.ext_clk_en = wb[TMR_BIT_EXT_CLK_EN];
          new_as           = wb[TMR_BIT_ASYNC_SEL] & sys_clk_from_rc_i;
          d.asy.async_sel  = new_as;
          if (new_as != q.asy.async_sel)
          begin
            // mode change: start clean rather than with half-moved values
            d.count       = TMR_RST_BYTE;
            d.compare     = TMR_RST_BYTE;
            d.ctrl_a      = TMR_RST_BYTE;
            d.tmp_count   = TMR_RST_BYTE;
            d.tmp_compare = TMR_RST_BYTE;
            d.tmp_ctrl_a  = TMR_RST_BYTE;
            d.asy.busy    = 4'h0;
            d.count_down  = 1'b0;
          end
        end
        TMR_IDX_SYNC_PSC:
        begin
          d.sync_mode = wb[TMR_BIT_SYNC_MODE];
          if (wb[TMR_BIT_PSC_RESET])
            d.psc_reset = 1'b1;
          else if (q.sync_mode && !wb[TMR_BIT_SYNC_MODE])
            d.psc_reset = 1'b0;
        end
        TMR_IDX_COUNT:
        begin
          d.tmp_count = wb;
          d.block_cmp = 1'b1;
          if (q.asy.async_sel)
            d.asy.busy[3] = 1'b1;
          else
            d.count = wb;
        end
        TMR_IDX_COMPARE:
        begin
          d.tmp_compare = wb;
          if (q.asy.async_sel)
            d.asy.busy[2] = 1'b1;
          else
            d.compare = wb;
        end
        TMR_IDX_CTRL_A:
        begin
          d.tmp_ctrl_a = wb & TMR_CTRL_A_MASK;
          if (q.asy.async_sel)
            d.asy.busy[1] = 1'b1;
          else
            d.ctrl_a = wb & TMR_CTRL_A_MASK;
        end
        TMR_IDX_CTRL_B:
        begin
          d.tmp_ctrl_b = wb & TMR_CTRL_B_MASK;
          if (q.asy.async_sel)
            d.asy.busy[0] = 1'b1;
          else
            d.ctrl_b = wb & TMR_CTRL_B_MASK;
        end
        default:
          d.block_cmp = q.block_cmp;
      endcase
    end

    // hardware sets after every clear path so a coincident event survives
    if (cmp_set)
      d.cmp_flag = 1'b1;
    if (ovf_set)
      d.ovf_flag = 1'b1;

    // read mux, reserved bits zero
    case (idx)
      TMR_IDX_IRQ_FLAGS: rd = {6'h00, q.cmp_flag, q.ovf_flag};
      TMR_IDX_IRQ_MASK:  rd = {6'h00, q.cmp_irq_en, q.ovf_irq_en};
      TMR_IDX_ASYNC_ST:  rd = {1'b0, q.asy.ext_clk_en, q.asy.async_sel, q.asy.busy[3:2],
                               1'b0, q.asy.busy[1:0]};
      TMR_IDX_SYNC_PSC:  rd = {q.sync_mode, 5'h00, q.psc_reset, 1'b0};
      TMR_IDX_COUNT:     rd = q.count;
      TMR_IDX_COMPARE:   rd = q.tmp_compare;
      TMR_IDX_CTRL_A:    rd = q.tmp_ctrl_a;
      TMR_IDX_CTRL_B:    rd = q.tmp_ctrl_b;
      default:           rd = TMR_RST_BYTE;
    endcase

    // one-cycle ack; unmapped addresses answer with zero
    d.ack   = req;
    d.rdata = req ? {24'h000000, rd} : 32'h00000000;

    // interrupt requests gated by enable and the global bit
    d.cmp_irq = d.cmp_irq_en & global_irq_en_i & d.cmp_flag;
    d.ovf_irq = d.ovf_irq_en & global_irq_en_i & d.ovf_flag;
  end

  // single state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  // outputs from state flops; crystal enable decoded from ext_clk_en, buffer enable from ext_clk_en and async_sel
  assign dat_o            = q.rdata;
  assign ack_o            = q.ack;
  assign compare_irq_o    = q.cmp_irq;
  assign overflow_irq_o   = q.ovf_irq;
  assign ext_clk_buf_en_o = q.asy.async_sel & q.asy.ext_clk_en;
  assign crystal_osc_en_o = ~q.asy.ext_clk_en;
  assign count_value_o    = q.count;

endmodule

// *** src/tmr_pkg.sv ***
// package for the 8-bit timer with asynchronous clock option
// assumes a 32-bit classic wishbone slave with byte addresses = 4 * index
package tmr_pkg;

  // register indexes, byte address is four times the index
  localparam logic [7:0] TMR_IDX_SYNC_PSC  = 8'h43;
  localparam logic [7:0] TMR_IDX_IRQ_MASK  = 8'h6E;
  localparam logic [7:0] TMR_IDX_ASYNC_ST  = 8'hB6;
  localparam logic [7:0] TMR_IDX_IRQ_FLAGS = 8'h35;
  localparam logic [7:0] TMR_IDX_CTRL_A    = 8'h44;
  localparam logic [7:0] TMR_IDX_CTRL_B    = 8'h46;
  localparam logic [7:0] TMR_IDX_COUNT     = 8'h47;
  localparam logic [7:0] TMR_IDX_COMPARE   = 8'h48;

  // field positions
  localparam int TMR_BIT_EXT_CLK_EN  = 6;
  localparam int TMR_BIT_ASYNC_SEL   = 5;
  localparam int TMR_BIT_CNT_BUSY    = 4;
  localparam int TMR_BIT_CMP_BUSY    = 3;
  localparam int TMR_BIT_CTLA_BUSY   = 1;
  localparam int TMR_BIT_CTLB_BUSY   = 0;
  localparam int TMR_BIT_CMP         = 1;
  localparam int TMR_BIT_OVF         = 0;
  localparam int TMR_BIT_SYNC_MODE   = 7;
  localparam int TMR_BIT_PSC_RESET   = 1;

  // readable bits of the control registers
  localparam logic [7:0] TMR_CTRL_A_MASK = 8'hC3;
  localparam logic [7:0] TMR_CTRL_B_MASK = 8'h07;

  // value after reset and count limits
  localparam logic [7:0] TMR_RST_BYTE = 8'h00;
  localparam logic [7:0] TMR_MAX      = 8'hFF;
  localparam logic [7:0] TMR_BOTTOM   = 8'h00;

  // waveform modes held in control_a[1:0]
  localparam logic [1:0] TMR_WGM_NORMAL = 2'h0;
  localparam logic [1:0] TMR_WGM_PHASE  = 2'h1;
  localparam logic [1:0] TMR_WGM_CTC    = 2'h2;

  typedef struct packed {
    logic       ext_clk_en;
    logic       async_sel;
    logic [3:0] busy;      // count, compare, ctrl_a, ctrl_b
  } tmr_async_s;

  typedef struct packed {
    logic [7:0]  count;
    logic [7:0]  compare;
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [7:0]  tmp_count;
    logic [7:0]  tmp_compare;
    logic [7:0]  tmp_ctrl_a;
    logic [7:0]  tmp_ctrl_b;
    tmr_async_s  asy;
    logic        cmp_irq_en;
    logic        ovf_irq_en;
    logic        cmp_flag;
    logic        ovf_flag;
    logic        sync_mode;
    logic        psc_reset;
    logic        count_down;
    logic        block_cmp;
    logic [9:0]  psc;
    logic        aclk_s1;
    logic        aclk_s2;
    logic        aclk_s3;
    logic        ack;
    logic [31:0] rdata;
    logic        cmp_irq;
    logic        ovf_irq;
  } tmr_state_s;

endpackage

// *** sim/tmr_timer0_sva.sv ***
// checker for the timer's bus, interrupt and clock-source ports
// assumes it is bound to tmr_timer0 and sees one clock domain only
module tmr_timer0_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic        global_irq_en_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        compare_irq_o,
  input wire logic        overflow_irq_o,
  input wire logic        crystal_osc_en_o,
  input wire logic        ext_clk_buf_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answer shape
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");
  a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  a_dat_upper_zero: assert property (dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  // only one clock source may be live at a time
  a_clk_src_excl: assert property (!(crystal_osc_en_o && ext_clk_buf_en_o))
    else $error("crystal and external buffer both enabled");
  a_osc_after_rst: assert property (disable iff (1'b0) rst_i |=> crystal_osc_en_o && !ext_clk_buf_en_o)
    else $error("clock source wrong after reset");
  // interrupts need the global enable
  a_cmp_irq_gate: assert property (compare_irq_o |-> $past(global_irq_en_i))
    else $error("compare interrupt without global enable");
  a_ovf_irq_gate: assert property (overflow_irq_o |-> $past(global_irq_en_i))
    else $error("overflow interrupt without global enable");
  a_irq_quiet: assert property (!global_irq_en_i [*2] |-> !compare_irq_o && !overflow_irq_o)
    else $error("interrupt while globally disabled");
  cover property (ack_o && we_i);
  cover property (compare_irq_o);
  cover property (overflow_irq_o);
  cover property (ext_clk_buf_en_o);
endmodule
bind tmr_timer0 tmr_timer0_chk chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .global_irq_en_i, .dat_o, .ack_o,
  .compare_irq_o, .overflow_irq_o, .crystal_osc_en_o, .ext_clk_buf_en_o);

// *** sim/tb_timer0_async_status_irq.sv ***
// bench for the timer: register sequences over classic wishbone
// assumes the design answers every request with a one-cycle ack
module tb_timer0_async_status_irq;
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, aclk, rc, glob, cvec, ovec, ack, xtal, xbuf, cirq, oirq;
  logic [9:0]  adr;
  logic [31:0] wdat, rdat;
  logic [7:0]  cnt, v;
  int          fail_count, tests_run;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
  tmr_timer0 dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .async_clk_i(aclk), .sys_clk_from_rc_i(rc),
    .global_irq_en_i(glob), .cmp_vector_ack_i(cvec), .ovf_vector_ack_i(ovec), .compare_irq_o(cirq),
    .overflow_irq_o(oirq), .crystal_osc_en_o(xtal), .ext_clk_buf_en_o(xbuf), .count_value_o(cnt));
  initial
  begin
    clk_i = 0;
    forever #2 clk_i = ~clk_i;
  end
  // one bus cycle; held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h0, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    v = rdat[7:0];
    cyc <= 0; stb <= 0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    bus(0, idx, 8'h00);
    `CHK("reg", e, v)
  endtask
  // one rising edge on the async pin, then let it cross over
  task automatic aedge();
    @(posedge clk_i); aclk <= 1;
    repeat (4) @(posedge clk_i);
    aclk <= 0;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic wrap_up();
    $display("tests %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end
  initial
  begin
    {cyc, stb, we, aclk, rc, glob, cvec, ovec} = '0; adr = '0; wdat = '0; rst_i = 1;
    fail_count = 0; tests_run = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    rd(TMR_IDX_ASYNC_ST, 8'h00); rd(TMR_IDX_IRQ_MASK, 8'h00); rd(TMR_IDX_IRQ_FLAGS, 8'h00);
    rd(TMR_IDX_SYNC_PSC, 8'h00); rd(8'h01, 8'h00);
    `CHK("xtal", 1'b1, xtal)
    bus(1, TMR_IDX_IRQ_MASK, 8'hFF); rd(TMR_IDX_IRQ_MASK, 8'h03);
    $display("reset and mask test done");
    // sync run with no prescale: wraps and matches within 300 ticks
    bus(1, TMR_IDX_COMPARE, 8'h05); bus(1, TMR_IDX_COUNT, 8'h00); bus(1, TMR_IDX_CTRL_B, 8'h01);
    repeat (300) @(posedge clk_i);
    bus(1, TMR_IDX_CTRL_B, 8'h00);
    rd(TMR_IDX_IRQ_FLAGS, 8'h03); rd(TMR_IDX_COMPARE, 8'h05);
    @(posedge clk_i); glob <= 1;
    repeat (3) @(posedge clk_i);
    `CHK("cirq", 1'b1, cirq)
    `CHK("oirq", 1'b1, oirq)
    glob <= 0;
    repeat (3) @(posedge clk_i);
    `CHK("cirq_off", 1'b0, cirq | oirq)
    bus(1, TMR_IDX_IRQ_FLAGS, 8'h00); rd(TMR_IDX_IRQ_FLAGS, 8'h03);
    @(posedge clk_i); cvec <= 1;
    @(posedge clk_i); cvec <= 0;
    rd(TMR_IDX_IRQ_FLAGS, 8'h01);
    @(posedge clk_i); ovec <= 1;
    @(posedge clk_i); ovec <= 0;
    rd(TMR_IDX_IRQ_FLAGS, 8'h00);
    bus(1, TMR_IDX_SYNC_PSC, 8'h02); rd(TMR_IDX_SYNC_PSC, 8'h00);
    $display("flag and interrupt test done");
    // select refused without the rc clock, then accepted with it
    bus(1, TMR_IDX_ASYNC_ST, 8'h20); rd(TMR_IDX_ASYNC_ST, 8'h00);
    @(posedge clk_i); rc <= 1;
    bus(1, TMR_IDX_ASYNC_ST, 8'h40); bus(1, TMR_IDX_ASYNC_ST, 8'h60); rd(TMR_IDX_ASYNC_ST, 8'h60);
    `CHK("xbuf", 2'b10, {xbuf, xtal})
    `CHK("cnt", 8'h00, cnt)
    rd(TMR_IDX_COUNT, 8'h00);
    bus(1, TMR_IDX_COMPARE, 8'h33); rd(TMR_IDX_ASYNC_ST, 8'h68); rd(TMR_IDX_COMPARE, 8'h33);
    aedge(); rd(TMR_IDX_ASYNC_ST, 8'h60);
    bus(1, TMR_IDX_SYNC_PSC, 8'h02); rd(TMR_IDX_SYNC_PSC, 8'h02);
    aedge(); rd(TMR_IDX_SYNC_PSC, 8'h00);
    bus(1, TMR_IDX_SYNC_PSC, 8'h82); aedge(); rd(TMR_IDX_SYNC_PSC, 8'h82);
    bus(1, TMR_IDX_SYNC_PSC, 8'h00); rd(TMR_IDX_SYNC_PSC, 8'h00);
    $display("async and prescaler test done");
    wrap_up();
  end
endmodule
